// ---- rsm_pkg.sv ----
// Constants, register map and state codes for the reset sequence manager.
package rsm_pkg;

   // Core clock period in nanoseconds (25 MHz).
   localparam int CLK_PERIOD_NS = 40;

   // Minimum width of the reset pulse this device drives out, in nanoseconds.
   localparam int MIN_OUT_PULSE_NS = 20000;
   // Least time rounds up to whole cycles, never less than one.
   localparam int MIN_OUT_PULSE_CYC_RAW = (MIN_OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_OUT_PULSE_CYC = (MIN_OUT_PULSE_CYC_RAW < 1) ? 1 : MIN_OUT_PULSE_CYC_RAW;

   // Oscillator stabilisation delay and vector fetch length in CPU clock cycles.
   localparam int STAB_CYC = 4096;
   localparam int FETCH_CYC = 2;

   // Phase counter width; holds the stabilisation count.
   localparam int CNT_W = 13;

   // Register bus.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] CAUSE_ADDR = 8'h2B;
   localparam logic [7:0] STATUS_ADDR = 8'h2C;

   // Reset cause register fields and reset values.
   localparam int BROWN_FLAG_BIT = 4;
   localparam int WDG_FLAG_BIT = 0;
   localparam logic BROWN_FLAG_RST = 1'b1;
   localparam logic WDG_FLAG_RST = 1'b0;

   // Reset vector location.
   localparam logic [15:0] VEC_ADDR_HI = 16'hFFFE;
   localparam logic [15:0] VEC_ADDR_LO = 16'hFFFF;

   // Number of selectable brown-out threshold levels.
   localparam int LVL_NUM = 3;

   // Main clock source types.
   typedef enum logic [1:0] {
      RSM_CLK_EXT = 2'h0,
      RSM_CLK_XTAL = 2'h1,
      RSM_CLK_EXT_RC = 2'h2,
      RSM_CLK_INT_RC = 2'h3
   } rsm_clk_src_t;

   // Reset sequence phases, one-hot.
   typedef enum logic [3:0] {
      RSM_RUN = 4'h1,
      RSM_DELAY = 4'h2,
      RSM_STAB = 4'h4,
      RSM_FETCH = 4'h8
   } rsm_state_t;

endpackage

// ---- rsm_reset_sequencer.sv ----
// Reset sequencer: merges pin, brown-out and watchdog resets and runs the reset phases.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rsm_reset_sequencer #(
   parameter int PULSE_CYC = rsm_pkg::MIN_OUT_PULSE_CYC,
   parameter int STAB_CYCLES = rsm_pkg::STAB_CYC
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   input wire logic [rsm_pkg::LVL_NUM-1:0] below_rising_i,
   input wire logic [rsm_pkg::LVL_NUM-1:0] below_falling_i,
   input wire logic wdg_underflow_i,
   input wire logic [1:0] opt_lvd_level_i,
   input wire logic [1:0] opt_clk_src_i,
   input wire logic [1:0] opt_xtal_range_i,
   input wire logic [rsm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [rsm_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [rsm_pkg::DATA_W-1:0] rdata_o,
   output logic cpu_rst_o,
   output logic vec_rd_o,
   output logic [15:0] vec_addr_o,
   input wire logic [7:0] vec_data_i,
   output logic [15:0] pc_o,
   output logic pc_load_o,
   output logic [1:0] clk_src_o,
   output logic [1:0] xtal_range_o,
   output logic osc_keep_on_o
);

   localparam logic [rsm_pkg::CNT_W-1:0] PULSE_LAST = rsm_pkg::CNT_W'(PULSE_CYC - 1);
   localparam logic [rsm_pkg::CNT_W-1:0] STAB_LAST = rsm_pkg::CNT_W'(STAB_CYCLES - 1);
   localparam logic [rsm_pkg::CNT_W-1:0] FETCH_LAST = rsm_pkg::CNT_W'(rsm_pkg::FETCH_CYC - 1);

   // Synchronisers for the asynchronous pin and comparator inputs.
   logic pin_s1_reg, pin_s2_reg;
   logic [rsm_pkg::LVL_NUM-1:0] rise_s1_reg, rise_s2_reg, fall_s1_reg, fall_s2_reg;
   logic catch_s1_reg, catch_s2_reg;
   logic catch_reg, catch_next;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_s1_reg <= 1'b0;
         pin_s2_reg <= 1'b0;
         rise_s1_reg <= '1;
         rise_s2_reg <= '1;
         fall_s1_reg <= '1;
         fall_s2_reg <= '1;
         catch_s1_reg <= 1'b0;
         catch_s2_reg <= 1'b0;
      end else begin
         pin_s1_reg <= rst_pin_i;
         pin_s2_reg <= pin_s1_reg;
         rise_s1_reg <= below_rising_i;
         rise_s2_reg <= rise_s1_reg;
         fall_s1_reg <= below_falling_i;
         fall_s2_reg <= fall_s1_reg;
         catch_s1_reg <= catch_reg;
         catch_s2_reg <= catch_s1_reg;
      end
   end

   // A low pin sets the catch flop without any clock; it clears once the sequence leaves run.
   rsm_pkg::rsm_state_t state_reg, state_next;
   logic catch_arst_n;

   assign catch_arst_n = nrst_i & rst_pin_i;

   always_comb begin
      catch_next = (state_reg == rsm_pkg::RSM_RUN) ? catch_reg : 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge catch_arst_n) begin
      if (!catch_arst_n) begin
         catch_reg <= 1'b1;
      end else begin
         catch_reg <= catch_next;
      end
   end

   // Option settings are captured only while the device is held in reset.
   logic [1:0] lvl_reg, lvl_next, src_reg, src_next, rng_reg, rng_next;
   logic brown_reg, brown_next;
   logic [1:0] lvl_idx;

   always_comb begin
      lvl_next = lvl_reg;
      src_next = src_reg;
      rng_next = rng_reg;
      if (state_reg == rsm_pkg::RSM_DELAY) begin
         lvl_next = opt_lvd_level_i;
         src_next = opt_clk_src_i;
         rng_next = opt_xtal_range_i;
      end
      lvl_idx = (lvl_reg > 2'(rsm_pkg::LVL_NUM - 1)) ? 2'(rsm_pkg::LVL_NUM - 1) : lvl_reg;
      // Hysteresis: leave brown-out above the rising level, enter it below the falling level.
      brown_next = brown_reg ? rise_s2_reg[lvl_idx] : fall_s2_reg[lvl_idx];
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lvl_reg <= 2'h0;
         src_reg <= 2'h0;
         rng_reg <= 2'h0;
         brown_reg <= 1'b1;
      end else begin
         lvl_reg <= lvl_next;
         src_reg <= src_next;
         rng_reg <= rng_next;
         brown_reg <= brown_next;
      end
   end

   // Phase sequencer with pin drive and vector fetch.
   logic [rsm_pkg::CNT_W-1:0] cnt_reg, cnt_next;
   logic drive_reg, drive_next;
   logic cpu_rst_reg, cpu_rst_next;
   logic vec_rd_reg, vec_rd_next;
   logic [15:0] vec_addr_reg, vec_addr_next;
   logic hi_due_reg, hi_due_next, lo_due_reg, lo_due_next;
   logic [15:0] pc_reg, pc_next;
   logic pc_load_reg, pc_load_next;
   logic wdg_evt;

   assign wdg_evt = (state_reg == rsm_pkg::RSM_RUN) && wdg_underflow_i;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      drive_next = drive_reg;
      unique case (state_reg)
         rsm_pkg::RSM_RUN: begin
            if (brown_reg || catch_s2_reg || wdg_evt) begin
               state_next = rsm_pkg::RSM_DELAY;
               cnt_next = '0;
               drive_next = 1'b1;
            end
         end
         rsm_pkg::RSM_DELAY: begin
            if (cnt_reg != PULSE_LAST) begin
               cnt_next = cnt_reg + 1'b1;
            end
            drive_next = brown_reg || (cnt_reg != PULSE_LAST);
            if (!drive_reg && !brown_reg && pin_s2_reg) begin
               state_next = rsm_pkg::RSM_STAB;
               cnt_next = '0;
            end
         end
         rsm_pkg::RSM_STAB: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == STAB_LAST) begin
               state_next = rsm_pkg::RSM_FETCH;
               cnt_next = '0;
            end
         end
         rsm_pkg::RSM_FETCH: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == FETCH_LAST) begin
               state_next = rsm_pkg::RSM_RUN;
               cnt_next = '0;
            end
         end
      endcase
      // A new brown-out or a pin held low restarts the sequence from the delay phase.
      if (state_reg != rsm_pkg::RSM_RUN && state_reg != rsm_pkg::RSM_DELAY &&
          (brown_reg || !pin_s2_reg)) begin
         state_next = rsm_pkg::RSM_DELAY;
         cnt_next = '0;
         drive_next = 1'b1;
      end
      vec_rd_next = (state_next == rsm_pkg::RSM_FETCH);
      vec_addr_next = (cnt_next == '0) ? rsm_pkg::VEC_ADDR_HI : rsm_pkg::VEC_ADDR_LO;
      hi_due_next = vec_rd_reg && (vec_addr_reg == rsm_pkg::VEC_ADDR_HI);
      lo_due_next = vec_rd_reg && (vec_addr_reg == rsm_pkg::VEC_ADDR_LO);
      pc_next = pc_reg;
      pc_load_next = 1'b0;
      if (hi_due_reg) begin
         pc_next[15:8] = vec_data_i;
      end
      if (lo_due_reg) begin
         pc_next[7:0] = vec_data_i;
         pc_load_next = (state_reg == rsm_pkg::RSM_RUN);
      end
      cpu_rst_next = cpu_rst_reg;
      if (state_next != rsm_pkg::RSM_RUN) begin
         cpu_rst_next = 1'b1;
      end else if (pc_load_next) begin
         cpu_rst_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= rsm_pkg::RSM_DELAY;
         cnt_reg <= '0;
         drive_reg <= 1'b1;
         cpu_rst_reg <= 1'b1;
         vec_rd_reg <= 1'b0;
         vec_addr_reg <= rsm_pkg::VEC_ADDR_HI;
         hi_due_reg <= 1'b0;
         lo_due_reg <= 1'b0;
         pc_reg <= 16'h0000;
         pc_load_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         drive_reg <= drive_next;
         cpu_rst_reg <= cpu_rst_next;
         vec_rd_reg <= vec_rd_next;
         vec_addr_reg <= vec_addr_next;
         hi_due_reg <= hi_due_next;
         lo_due_reg <= lo_due_next;
         pc_reg <= pc_next;
         pc_load_reg <= pc_load_next;
      end
   end

   // Cause flags and register read port; a hardware set wins over a software clear.
   logic brown_flag_reg, brown_flag_next, wdg_flag_reg, wdg_flag_next;
   logic [rsm_pkg::DATA_W-1:0] rdata_reg, rdata_next;
   logic osc_keep_reg, osc_keep_next;
   logic cause_wr;

   assign cause_wr = wr_i && (addr_i == rsm_pkg::CAUSE_ADDR);

   always_comb begin
      brown_flag_next = brown_flag_reg;
      wdg_flag_next = wdg_flag_reg;
      if (cause_wr && !wdata_i[rsm_pkg::BROWN_FLAG_BIT]) begin
         brown_flag_next = 1'b0;
      end
      if (cause_wr && !wdata_i[rsm_pkg::WDG_FLAG_BIT]) begin
         wdg_flag_next = 1'b0;
      end
      if (brown_reg) begin
         brown_flag_next = 1'b1;
         wdg_flag_next = 1'b0;
      end else if (wdg_evt) begin
         wdg_flag_next = 1'b1;
      end
      rdata_next = '0;
      if (rd_i && addr_i == rsm_pkg::CAUSE_ADDR) begin
         rdata_next[rsm_pkg::BROWN_FLAG_BIT] = brown_flag_reg;
         rdata_next[rsm_pkg::WDG_FLAG_BIT] = wdg_flag_reg;
      end else if (rd_i && addr_i == rsm_pkg::STATUS_ADDR) begin
         rdata_next = {src_reg, rng_reg, lvl_reg, brown_reg, drive_reg};
      end
      osc_keep_next = (src_reg == rsm_pkg::RSM_CLK_XTAL);
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         brown_flag_reg <= rsm_pkg::BROWN_FLAG_RST;
         wdg_flag_reg <= rsm_pkg::WDG_FLAG_RST;
         rdata_reg <= '0;
         osc_keep_reg <= 1'b0;
      end else begin
         brown_flag_reg <= brown_flag_next;
         wdg_flag_reg <= wdg_flag_next;
         rdata_reg <= rdata_next;
         osc_keep_reg <= osc_keep_next;
      end
   end

   // The pin is open drain: it only ever pulls low.
   assign rst_pin_o = 1'b0;
   assign rst_pin_oe_o = drive_reg;
   assign rdata_o = rdata_reg;
   assign cpu_rst_o = cpu_rst_reg;
   assign vec_rd_o = vec_rd_reg;
   assign vec_addr_o = vec_addr_reg;
   assign pc_o = pc_reg;
   assign pc_load_o = pc_load_reg;
   assign clk_src_o = src_reg;
   assign xtal_range_o = rng_reg;
   assign osc_keep_on_o = osc_keep_reg;

   localparam int PULSE_MIN = PULSE_CYC - 1;

   a_brown_holds_pin: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      brown_reg |=> drive_reg) else $error("Pin released during brown-out.");
   a_pulse_min_width: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $fell(drive_reg) |-> $past(cnt_reg) >= PULSE_MIN) else $error("Reset pulse too short.");
   a_stab_count_done: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == rsm_pkg::RSM_FETCH) && $past(state_reg) == rsm_pkg::RSM_STAB
      |-> $past(cnt_reg) == STAB_LAST) else $error("Stabilisation count cut short.");
   a_fetch_two_cycles: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $rose(state_reg == rsm_pkg::RSM_FETCH) && !brown_reg && pin_s2_reg
      |-> (state_reg == rsm_pkg::RSM_FETCH) ##1 (state_reg == rsm_pkg::RSM_FETCH)
      ##1 (state_reg != rsm_pkg::RSM_FETCH)) else $error("Fetch phase length wrong.");
   a_vector_address: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $rose(vec_rd_reg) |-> vec_addr_reg == rsm_pkg::VEC_ADDR_HI
      ##1 vec_addr_reg == rsm_pkg::VEC_ADDR_LO) else $error("Vector address wrong.");
   a_brown_flag_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      brown_reg |=> brown_flag_reg && !wdg_flag_reg) else $error("Brown-out flags wrong.");
   a_brown_flag_kept: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      brown_flag_reg && !(cause_wr && !wdata_i[rsm_pkg::BROWN_FLAG_BIT])
      |=> brown_flag_reg) else $error("Brown-out flag lost.");
   a_wdg_starts_reset: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wdg_evt && !brown_reg |=> wdg_flag_reg && drive_reg
      && state_reg == rsm_pkg::RSM_DELAY) else $error("Watchdog reset not started.");
   a_ext_starts_reset: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == rsm_pkg::RSM_RUN) && catch_s2_reg
      |=> drive_reg && state_reg == rsm_pkg::RSM_DELAY) else $error("Pin reset missed.");
   a_crystal_kept_on: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      src_reg == rsm_pkg::RSM_CLK_XTAL |=> osc_keep_on_o) else $error("Crystal not kept on.");

   c_reset_complete: cover property (@(posedge core_clk_i) disable iff (!nrst_i) pc_load_reg);
   c_watchdog_reset: cover property (@(posedge core_clk_i) disable iff (!nrst_i) wdg_evt);
   c_pin_reset: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == rsm_pkg::RSM_RUN) && catch_s2_reg);
   c_brown_in_run: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == rsm_pkg::RSM_RUN) && brown_reg);

endmodule

// ---- rsm_board_model.sv ----
// Board side of the reset pin and the memory that holds the reset vector.
`timescale 1ns/1ps
module rsm_board_model #(
   parameter logic [7:0] VEC_HI = 8'hC3,
   parameter logic [7:0] VEC_LO = 8'h5A
) (
   input wire logic core_clk_i,
   input wire logic ext_pull_i,
   input wire logic dev_pin_i,
   input wire logic dev_pin_oe_i,
   input wire logic vec_rd_i,
   input wire logic [15:0] vec_addr_i,
   output logic pin_level_o,
   output logic [7:0] vec_data_o
);
   // The pin is open drain with a pull-up, so it idles high.
   assign pin_level_o = ((dev_pin_oe_i & ~dev_pin_i) | ext_pull_i) ? 1'b0 : 1'b1;
   // Outside a fetch the data lines toggle, so a late sample shows garbage.
   always_ff @(posedge core_clk_i) begin
      if (vec_rd_i) begin
         vec_data_o <= (vec_addr_i == 16'hFFFE) ? VEC_HI :
                       (vec_addr_i == 16'hFFFF) ? VEC_LO : ~vec_addr_i[7:0];
      end else begin
         vec_data_o <= ~vec_data_o;
      end
   end
endmodule

// ---- tb_rsm_reset_sequencer.sv ----
// Self-checking testbench for the reset sequencer.
`timescale 1ns/1ps
module tb_rsm_reset_sequencer;
   localparam int PULSE = 4;
   localparam int STAB = 16;
   localparam int PULL_CYC = 6;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic ext_pull = 1'b0;
   logic pin_level, pin_o, pin_oe, wdg = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [2:0] below_r = 3'h7, below_f = 3'h7;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, vec_data;
   logic cpu_rst, vec_rd, pc_load, osc_keep;
   logic [15:0] vec_addr, pc;
   logic [1:0] clk_src, xtal;
   logic [1:0] opt_lvl = 2'h1, opt_src = 2'h1;
   int oe_run = 0;
   int oe_width = 0;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;

   rsm_reset_sequencer #(.PULSE_CYC(PULSE), .STAB_CYCLES(STAB)) u_dut (
      .core_clk_i(core_clk), .nrst_i(nrst), .rst_pin_i(pin_level), .rst_pin_o(pin_o),
      .rst_pin_oe_o(pin_oe), .below_rising_i(below_r), .below_falling_i(below_f),
      .wdg_underflow_i(wdg), .opt_lvd_level_i(opt_lvl), .opt_clk_src_i(opt_src),
      .opt_xtal_range_i(2'h2), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .cpu_rst_o(cpu_rst), .vec_rd_o(vec_rd), .vec_addr_o(vec_addr),
      .vec_data_i(vec_data), .pc_o(pc), .pc_load_o(pc_load), .clk_src_o(clk_src),
      .xtal_range_o(xtal), .osc_keep_on_o(osc_keep));
   rsm_board_model u_board (
      .core_clk_i(core_clk), .ext_pull_i(ext_pull), .dev_pin_i(pin_o), .dev_pin_oe_i(pin_oe),
      .vec_rd_i(vec_rd), .vec_addr_i(vec_addr), .pin_level_o(pin_level),
      .vec_data_o(vec_data));

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // Width in cycles of the last completed stretch in which the device drove the pin.
   always @(posedge core_clk) begin
      if (pin_oe === 1'b1) begin
         oe_run <= oe_run + 1;
      end else begin
         if (oe_run != 0) begin
            oe_width <= oe_run;
         end
         oe_run <= 0;
      end
   end

   task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      cmp("rdata", {8'h00, exp}, {8'h00, rdata});
   endtask

   task automatic wait_drive();
      int n;
      n = 0;
      while (pin_oe !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      cmp("pin_drive", 16'h0001, {15'h0, pin_oe});
   endtask

   // Follows one reset from the driven pin to the loaded program counter.
   task automatic finish_seq();
      int n;
      int m;
      int k;
      n = 0;
      m = 0;
      k = 0;
      #1;
      while (pin_oe === 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      tick(1);
      cmp("pulse_long", 16'h0001, {15'h0, oe_width >= PULSE});
      while (vec_rd !== 1'b1 && m < 100) begin
         cmp("cpu_held", 16'h0001, {15'h0, cpu_rst});
         tick(1);
         m++;
      end
      cmp("stab_len", 16'h0001, {15'h0, m >= STAB && m <= STAB + 6});
      while (vec_rd === 1'b1 && k < 10) begin
         cmp("vec_addr", (k == 0) ? 16'hFFFE : 16'hFFFF, vec_addr);
         tick(1);
         k++;
      end
      cmp("fetch_len", 16'h0002, k[15:0]);
      m = 0;
      while (pc_load !== 1'b1 && m < 8) begin
         tick(1);
         m++;
      end
      cmp("pc", 16'hC35A, pc);
      tick(2);
      cmp("cpu_rst", 16'h0000, {15'h0, cpu_rst});
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   initial begin
      tick(2);
      nrst <= 1'b1;
      tick(12);
      cmp("por_hold", 16'h0001, {15'h0, pin_oe});
      below_r <= 3'h0;
      below_f <= 3'h0;
      finish_seq();
      bus_rd(8'h2B, 8'h10);
      bus_rd(8'h2C, 8'h64);
      cmp("osc_keep", 16'h0001, {15'h0, osc_keep});
      cmp("clk_sel", 16'h0006, {12'h0, clk_src, xtal});
      bus_wr(8'h2B, 8'hFF);
      bus_rd(8'h2B, 8'h10);
      bus_wr(8'h2B, 8'h00);
      bus_rd(8'h2B, 8'h00);
      bus_wr(8'h2C, 8'h00);
      bus_rd(8'h2C, 8'h64);
      bus_rd(8'h30, 8'h00);
      @(posedge core_clk);
      wdg <= 1'b1;
      @(posedge core_clk);
      wdg <= 1'b0;
      #1;
      cmp("wdg_drive", 16'h0001, {15'h0, pin_oe});
      finish_seq();
      bus_rd(8'h2B, 8'h01);
      // The board holds the pin low longer than the minimum input width.
      @(posedge core_clk);
      ext_pull <= 1'b1;
      tick(PULL_CYC);
      wait_drive();
      @(posedge core_clk);
      ext_pull <= 1'b0;
      finish_seq();
      bus_rd(8'h2B, 8'h01);
      below_r <= 3'h7;
      below_f <= 3'h1;
      tick(12);
      cmp("hyst_run", 16'h0000, {15'h0, pin_oe});
      below_f <= 3'h3;
      wait_drive();
      below_f <= 3'h0;
      tick(20);
      cmp("hyst_hold", 16'h0001, {15'h0, pin_oe});
      below_r <= 3'h0;
      finish_seq();
      bus_rd(8'h2B, 8'h10);
      @(posedge core_clk);
      wdg <= 1'b1;
      @(posedge core_clk);
      wdg <= 1'b0;
      wait_drive();
      finish_seq();
      bus_rd(8'h2B, 8'h11);
      // Level code 3 acts as the highest level; the clock source becomes external RC.
      opt_lvl <= 2'h3;
      opt_src <= 2'h2;
      @(posedge core_clk);
      wdg <= 1'b1;
      @(posedge core_clk);
      wdg <= 1'b0;
      wait_drive();
      finish_seq();
      bus_rd(8'h2C, 8'hAC);
      cmp("osc_keep", 16'h0000, {15'h0, osc_keep});
      cmp("clk_sel", 16'h000A, {12'h0, clk_src, xtal});
      below_f <= 3'h3;
      tick(12);
      cmp("lvl_clamp", 16'h0000, {15'h0, pin_oe});
      below_f <= 3'h4;
      wait_drive();
      tally_and_finish();
   end
endmodule
